// ===== sopwm_top.sv
// What this block does
// - Standard mode: three pairs, own period, own duty
// - Powers up in H-bridge mode, motor off
// - Output edges come from count versus compares
// - Standard mode: pair k drives out(2k) and out(2k+1)
// - Prescale field 8:6 divides clock by 2^(n+1)
// - Sixteen-bit timer; period length sets period
// - High side rises at compare 0, falls compare 1
// - Low side rises at length, falls compare 2/high
// - Sync enable: falling sync edge clears all counters
// - Bit 13 inverts out5; bits 12,11 invert out3, out1 in standard mode
// - Trip enable: low trip clears enable, interrupts
// - Bridge output enable acts only in bridge mode
// - Control resets to 0x12; bit 1 selects mode
// - High-side-off: 1010 pattern; else bridge disabled: all high
// - Direction picks pair; idle pair low or inverted
module sopwm_top (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response.
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Outside pins.
    input  wire logic        external_sync_pin,
    input  wire logic        fault_trip_input,
    // Modulator outputs and interrupt.
    output logic             out0,
    output logic             out1,
    output logic             out2,
    output logic             out3,
    output logic             out4,
    output logic             out5,
    output logic             irq
);
    import sopwm_pkg::*;

    sopwm_ctrl_type     ctrl_q;
    sopwm_pair_cfg_type pair_cfg_q [3];
    logic [2:0]         hs;
    logic [2:0]         ls;
    logic [2:0]         wrap;
    logic [15:0]        pair_count [3];
    logic [IRQ_W-1:0]   irq_status_q;
    logic [IRQ_W-1:0]   irq_enable_q;
    logic [IRQ_W-1:0]   irq_set;
    logic [IRQ_W-1:0]   irq_clr;
    logic [5:0]         out_q;
    logic [5:0]         out_d;
    logic               irq_q;
    logic [7:0]         presc_q;
    logic [7:0]         presc_limit;
    logic               tick;
    logic               sync_prev_q;
    logic               sync_clr;
    logic               trip_hit;

    // Bus handshake state.
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [7:0]  waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d, awready_q, wready_q;
    logic        rvalid_q, rvalid_d, arready_q;
    logic [1:0]  bresp_q, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        do_write, ar_take;
    logic        wr_pair, wr_known;
    logic [7:0]  wr_rel;

    // Byte lanes 0 and 1 carry the sixteen-bit registers.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = old;
        if (strb[0]) merge16[7:0] = data[7:0];
        if (strb[1]) merge16[15:8] = data[15:8];
    endfunction

    // Address and data are parked independently, then written together.
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        if (awvalid && awready_q) begin
            aw_held_d = 1'b1;
            waddr_d   = awaddr;
        end
        if (wvalid && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = wdata;
            wstrb_d  = wstrb;
        end
        do_write = aw_held_q && w_held_q && !bvalid_q;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
        end
        bvalid_d = (bvalid_q && !bready) || do_write;
    end

    // Write decode of the parked address.
    assign wr_rel   = waddr_q - OFF_PAIR_FIRST;
    assign wr_pair  = waddr_q >= OFF_PAIR_FIRST && waddr_q <= OFF_PAIR_LAST;
    assign wr_known = waddr_q[1:0] == 2'h0 && (wr_pair
                      || waddr_q == OFF_CTRL || waddr_q == OFF_TRIP_CLEAR
                      || waddr_q == OFF_IRQ_STATUS
                      || waddr_q == OFF_IRQ_CLEAR
                      || waddr_q == OFF_IRQ_ENABLE);

    // Write channel registers; ready drops while a word is parked.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            awready_q <= !aw_held_d && !bvalid_d;
            wready_q  <= !w_held_d && !bvalid_d;
            if (do_write) begin
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Read data is taken on the same edge as the address.
    always_comb begin
        ar_take  = arvalid && arready_q;
        rvalid_d = (rvalid_q && !rready) || ar_take;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (ar_take) begin
            rdata_d = 32'h0000_0000;
            rresp_d = RESP_OKAY;
            if (araddr[1:0] != 2'h0) begin
                rresp_d = RESP_SLVERR;
            end else if (araddr == OFF_CTRL) begin
                rdata_d[15:0] = ctrl_q;
            end else if (araddr >= OFF_PAIR_FIRST
                         && araddr <= OFF_PAIR_LAST) begin
                rdata_d[15:0] = pair_cfg_q[2'(araddr - OFF_PAIR_FIRST
                                             >> 4)]
                                [16*((araddr - OFF_PAIR_FIRST) >> 2 & 3)
                                 +: 16];
            end else if (araddr == OFF_IRQ_STATUS) begin
                rdata_d[IRQ_W-1:0] = irq_status_q;
            end else if (araddr == OFF_IRQ_ENABLE) begin
                rdata_d[IRQ_W-1:0] = irq_enable_q;
            end else if (araddr != OFF_TRIP_CLEAR
                         && araddr != OFF_IRQ_CLEAR) begin
                rresp_d = RESP_SLVERR;
            end
        end
    end

    // Read channel registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else begin
            rvalid_q  <= rvalid_d;
            arready_q <= !rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign trip_hit = ctrl_q.fault_trip_irq_enable && !fault_trip_input;

    // A trip in the same cycle as a control write still clears the enable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= sopwm_ctrl_type'(CTRL_RESET);
        end else begin
            if (do_write && waddr_q == OFF_CTRL) begin
                ctrl_q <= sopwm_ctrl_type'(merge16(ctrl_q, wdata_q, wstrb_q)
                                           & CTRL_MASK);
            end
            if (trip_hit) begin
                ctrl_q.all_outputs_enable <= 1'b0;
            end
        end
    end

    assign presc_limit = 8'((9'h002 << ctrl_q.clock_prescale_select)
                            - 9'h001);
    assign tick        = presc_q >= presc_limit;

    // The divider restarts with the counters so a sync lands on a tick grid.
    always_ff @(posedge aclk) begin
        if (!aresetn || sync_clr || tick) begin
            presc_q <= PRESC_RESET;
        end else begin
            presc_q <= presc_q + 8'h01;
        end
    end

    assign sync_clr = ctrl_q.sync_enable && sync_prev_q && !external_sync_pin;

    // The pin is taken as synchronous, so one stage finds the edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_prev_q <= 1'b1;
        end else begin
            sync_prev_q <= external_sync_pin;
        end
    end

    for (genvar k = 0; k < 3; k++) begin : g_pair
        logic [1:0] fld;
        assign fld = wr_rel[3:2];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pair_cfg_q[k] <= {4{CMP_RESET}};
            end else if (do_write && wr_pair && waddr_q[1:0] == 2'h0
                         && wr_rel[5:4] == 2'(k)) begin
                pair_cfg_q[k][16*fld +: 16] <=
                    merge16(pair_cfg_q[k][16*fld +: 16], wdata_q, wstrb_q);
            end
        end

        sopwm_pair u_pair (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .tick         (tick),
            .sync_clr     (sync_clr),
            .load_compare (ctrl_q.load_compare),
            .cfg          (pair_cfg_q[k]),
            .hs_q         (hs[k]),
            .ls_q         (ls[k]),
            .count_q      (pair_count[k]),
            .wrap_q       (wrap[k])
        );
    end

    // Output selection.
    always_comb begin
        out_d = {ls[2] ^ ctrl_q.out5_invert, hs[2],
                 ls[1] ^ ctrl_q.out3_invert, hs[1],
                 ls[0] ^ ctrl_q.out1_invert, hs[0]};
        if (ctrl_q.bridge_mode_select) begin
            out_d[5:4] = out_d[5:4] ^ {2{ctrl_q.all_output_invert}};
        end
        if (!ctrl_q.all_outputs_enable) begin
            out_d = 6'h00;
        end
        if (ctrl_q.bridge_mode_select) begin
            if (ctrl_q.high_side_off) begin
                out_d[3:0] = 4'h5;
            end else if (!ctrl_q.bridge_output_enable) begin
                out_d[3:0] = 4'hf;
            end else if (ctrl_q.direction) begin
                out_d[3:0] = {{2{ctrl_q.all_output_invert}}, ls[0], hs[0]};
            end else begin
                out_d[3:0] = {ls[0], hs[0], {2{ctrl_q.all_output_invert}}};
            end
        end
    end

    // Every pin leaves from a flop so glitches never reach the bridge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= 6'h00;
        end else begin
            out_q <= out_d;
        end
    end

    // Events and clears; a set in the clearing cycle survives.
    always_comb begin
        irq_set           = '0;
        irq_set[IRQ_TRIP] = trip_hit;
        irq_set[IRQ_SYNC] = sync_clr;
        irq_set[IRQ_WRAP] = wrap[0];
        irq_clr           = '0;
        if (do_write && waddr_q == OFF_IRQ_CLEAR && wstrb_q[0]) begin
            irq_clr = wdata_q[IRQ_W-1:0];
        end
        if (do_write && waddr_q == OFF_TRIP_CLEAR) begin
            irq_clr[IRQ_TRIP] = 1'b1;
        end
    end

    // Status, enable and the level interrupt.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= '0;
            irq_enable_q <= '0;
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            if (do_write && waddr_q == OFF_IRQ_ENABLE && wstrb_q[0]) begin
                irq_enable_q <= wdata_q[IRQ_W-1:0];
            end
            irq_q <= |(irq_status_q & irq_enable_q);
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    assign {out5, out4, out3, out2, out1, out0} = out_q;
    assign irq     = irq_q;

    AST_CTRL_RESET: assert property (@(posedge aclk)
        $rose(aresetn) |-> ctrl_q == CTRL_RESET)
        else $error("Control register not at reset value.");

    AST_TRIP_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        trip_hit |=> !ctrl_q.all_outputs_enable && irq_status_q[IRQ_TRIP])
        else $error("Trip did not clear enable and flag.");

    AST_TRIP_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_status_q[IRQ_TRIP]) |->
            $past(ctrl_q.fault_trip_irq_enable && !fault_trip_input))
        else $error("Trip flag set without an enabled trip.");

    AST_SYNC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_clr |=> pair_count[0] == 16'h0000 && pair_count[2] == 16'h0000)
        else $error("Sync edge did not clear the counters.");

    AST_HIGH_SIDE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q.bridge_mode_select && ctrl_q.high_side_off
            |=> out_q[3:0] == 4'h5)
        else $error("High side off pattern wrong.");

    AST_BRIDGE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q.bridge_mode_select && !ctrl_q.high_side_off
            && !ctrl_q.bridge_output_enable |=> out_q[3:0] == 4'hf)
        else $error("Disabled bridge outputs not all high.");

    AST_DIR_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q.bridge_mode_select && !ctrl_q.high_side_off
            && ctrl_q.bridge_output_enable && ctrl_q.direction
            && !ctrl_q.all_output_invert
            |=> out_q[3:0] == {2'h0, $past(ls[0]), $past(hs[0])})
        else $error("Direction routing wrong.");

    AST_INV5: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q.bridge_mode_select && ctrl_q.all_outputs_enable
            |=> out_q[5] == $past(ls[2] ^ ctrl_q.out5_invert))
        else $error("Output 5 inversion wrong.");

    AST_PRESC_DIV2: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && ctrl_q.clock_prescale_select == 3'h0 |=> !tick)
        else $error("Divide by two ticked twice in a row.");

endmodule

// ===== sopwm_pkg.sv
package sopwm_pkg;

    // Register byte offsets on the AXI4-Lite port.
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_PAIR_FIRST = 8'h04;
    localparam logic [7:0] OFF_PAIR_LAST  = 8'h33;
    localparam logic [7:0] OFF_TRIP_CLEAR = 8'h38;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h3c;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h40;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h44;

    // Values after reset, and the control write mask.
    localparam logic [15:0] CTRL_RESET   = 16'h0012;
    localparam logic [15:0] CTRL_MASK    = 16'h7fff;
    localparam logic [15:0] CMP_RESET    = 16'h0000;
    localparam logic [7:0]  PRESC_RESET  = 8'h00;

    // Interrupt status bit positions.
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_SYNC = 1;
    localparam int IRQ_WRAP = 2;
    localparam int IRQ_W    = 3;

    // Compare field index inside a pair block.
    localparam logic [1:0] FLD_RISE    = 2'h0;
    localparam logic [1:0] FLD_FALL    = 2'h1;
    localparam logic [1:0] FLD_LOW_END = 2'h2;
    localparam logic [1:0] FLD_LEN     = 2'h3;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Main control register layout, bit 15 down to bit 0.
    typedef struct packed {
        logic       reserved;
        logic       sync_enable;
        logic       out5_invert;
        logic       out3_invert;
        logic       out1_invert;
        logic       fault_trip_irq_enable;
        logic       bridge_output_enable;
        logic [2:0] clock_prescale_select;
        logic       all_output_invert;
        logic       high_side_off;
        logic       load_compare;
        logic       direction;
        logic       bridge_mode_select;
        logic       all_outputs_enable;
    } sopwm_ctrl_type;

    // Programmed settings of one output pair.
    typedef struct packed {
        logic [15:0] period_length;
        logic [15:0] compare_low_end;
        logic [15:0] compare_fall;
        logic [15:0] compare_rise;
    } sopwm_pair_cfg_type;

endpackage

// ===== sopwm_pair.sv
module sopwm_pair (
    // Clock and reset.
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Timing controls.
    input  wire logic                          tick,
    input  wire logic                          sync_clr,
    input  wire logic                          load_compare,
    input  wire sopwm_pkg::sopwm_pair_cfg_type cfg,
    // Waveforms and timer state.
    output logic                               hs_q,
    output logic                               ls_q,
    output logic [15:0]                        count_q,
    output logic                               wrap_q
);
    import sopwm_pkg::*;

    logic [15:0] rise_q;
    logic [15:0] fall_q;
    logic [15:0] low_end_q;
    logic        at_len;
    logic        at_rise;
    logic        at_fall;
    logic        at_low_end;
    logic        step;

    // Edges are judged on the internal compare copies and the live period length.
    assign step       = tick && !sync_clr;
    assign at_len     = count_q == cfg.period_length;
    assign at_rise    = count_q == rise_q;
    assign at_fall    = count_q == fall_q;
    assign at_low_end = count_q == low_end_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || sync_clr) begin
            count_q <= CMP_RESET;
        end else if (tick) begin
            count_q <= at_len ? CMP_RESET : count_q + 16'h0001;
        end
    end

    // One-cycle pulse at the end of each period.
    always_ff @(posedge aclk) begin
        wrap_q <= aresetn && step && at_len;
    end

    // Copies reload only on the 0 to 1 step, so a period never tears.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_q    <= CMP_RESET;
            fall_q    <= CMP_RESET;
            low_end_q <= CMP_RESET;
        end else if (step && load_compare && count_q == CMP_RESET) begin
            rise_q    <= cfg.compare_rise;
            fall_q    <= cfg.compare_fall;
            low_end_q <= cfg.compare_low_end;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_q <= 1'b0;
        end else if (step && at_fall) begin
            hs_q <= 1'b0;
        end else if (step && at_rise) begin
            hs_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ls_q <= 1'b0;
        end else if (step && at_len) begin
            ls_q <= 1'b1;
        end else if (step && (at_low_end || (at_fall && hs_q))) begin
            ls_q <= 1'b0;
        end
    end

    AST_WRAP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && at_len |=> count_q == 16'h0000)
        else $error("Timer did not wrap to zero at period length.");

    AST_HS_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
        step && at_rise && !at_fall |=> hs_q)
        else $error("High side did not rise at compare rise.");

    AST_LS_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
        step && at_len |=> ls_q)
        else $error("Low side did not rise at period length.");

endmodule

// ===== sopwm_stage_model.sv
module sopwm_stage_model (
    // Clock.
    input  wire logic aclk,
    // Bridge drive lines.
    input  wire logic out0,
    input  wire logic out1,
    input  wire logic out2,
    input  wire logic out3,
    // Sync and trip lines.
    output logic      external_sync_pin,
    output logic      fault_trip_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines rest high, as pull-ups on the stage would hold them.
    initial begin
        external_sync_pin = 1'b1;
        fault_trip_input  = 1'b1;
    end
    // One low cycle on the sync line; only the fall matters.
    task automatic sync_pulse();
        @(posedge aclk);
        external_sync_pin <= 1'b0;
        @(posedge aclk);
        external_sync_pin <= 1'b1;
    endtask
    // A low trip level reports a fault in the power stage.
    task automatic set_trip(input logic lvl);
        @(posedge aclk);
        fault_trip_input <= lvl;
    endtask
    // High time of each bridge line over whole periods is phase-free.
    task automatic measure(input int n, output int h[4]);
        h = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge aclk);
            h[0] += int'(out0);
            h[1] += int'(out1);
            h[2] += int'(out2);
            h[3] += int'(out3);
        end
    endtask
endmodule

// ===== test_six_output_pwm_hbridge.sv
module test_six_output_pwm_hbridge;
    timeunit 1ns;
    timeprecision 1ns;
    import sopwm_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, irq;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        external_sync_pin, fault_trip_input;
    logic        out0, out1, out2, out3, out4, out5;
    int          n_errors = 0, tests_run = 0, h[4];
    logic [15:0] cfg[6] = '{16'h8, 16'h9, 16'h49, 16'h809, 16'h20f, 16'h22f};
    int          win[6] = '{44, 44, 88, 44, 44, 44};
    int          e0[6]  = '{0, 12, 24, 12, 12, 12};
    int          e1[6]  = '{0, 24, 48, 20, 24, 24};
    // Free-running 50 MHz clock.
    always #10 aclk = ~aclk;
    sopwm_top sopwm_top_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq),
        .external_sync_pin(external_sync_pin),
        .fault_trip_input(fault_trip_input), .out0(out0), .out1(out1),
        .out2(out2), .out3(out3), .out4(out4), .out5(out5));
    sopwm_stage_model stage_inst (.aclk(aclk), .out0(out0), .out1(out1),
        .out2(out2), .out3(out3), .external_sync_pin(external_sync_pin),
        .fault_trip_input(fault_trip_input));
    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        tests_run++;
        if (got !== ex) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // A stuck handshake would hang the run, so every wait is bounded.
    task automatic hang(input int i);
        if (i >= 50) begin
            chk("handshake", 32'h1, 32'h0);
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        hang(i);
        bready <= 1'b0;
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        hang(i);
        d = rdata;
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // Main sequence: each scenario is a run of bus calls and compares.
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(OFF_CTRL, RESP_OKAY);
        chk("ctrl_reset", {16'h0, CTRL_RESET}, d);
        chk("bridge_off", 32'ha, {28'h0, out0, out1, out2, out3});
        rd(8'h34, RESP_SLVERR);
        chk("unmapped", 32'h0, d);
        wr(OFF_CTRL, 32'h2);
        repeat (2) @(posedge aclk);
        chk("bridge_dis", 32'hf, {28'h0, out0, out1, out2, out3});
        for (int k = 0; k < 4; k++) begin
            wr(8'h04 + 8'(4 * k), k < 3 ? k * 3 + 2 : 10);
        end
        rd(8'h08, RESP_OKAY);
        chk("pair0_fall", 32'h5, d);
        for (int k = 0; k < 6; k++) begin
            wr(OFF_CTRL, {16'h0, cfg[k]});
            repeat (100) @(posedge aclk);
            stage_inst.measure(win[k], h);
            chk("high_side", e0[k], h[0]);
            chk("low_side", e1[k], h[1]);
            // Pair 2 keeps zero compares, so out4 stays low and out5 high; bridge-mode invert (k 5) swaps them.
            if (k == 1 || k == 5) begin
                chk("pair2_pins", k == 1 ? 2 : 1, {30'h0, out5, out4});
            end
            if (k > 3) begin
                chk("idle_a", k == 5 ? 44 : 0, h[2]);
                chk("idle_b", k == 5 ? 44 : 0, h[3]);
            end
        end
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h7);
        stage_inst.set_trip(1'b0);
        repeat (3) @(posedge aclk);
        rd(OFF_IRQ_STATUS, RESP_OKAY);
        chk("trip_off", 32'h0, d & 32'h3);
        wr(OFF_CTRL, 32'h409);
        repeat (3) @(posedge aclk);
        chk("trip_irq", 32'h1, {31'h0, irq});
        stage_inst.set_trip(1'b1);
        rd(OFF_CTRL, RESP_OKAY);
        chk("trip_ctrl", 32'h408, d);
        wr(OFF_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wr(OFF_TRIP_CLEAR, 32'h5a);
        repeat (2) @(posedge aclk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        stage_inst.sync_pulse();
        repeat (2) @(posedge aclk);
        rd(OFF_IRQ_STATUS, RESP_OKAY);
        chk("sync_off", 32'h0, d & 32'h3);
        wr(OFF_CTRL, 32'h4009);
        stage_inst.sync_pulse();
        repeat (2) @(posedge aclk);
        rd(OFF_IRQ_STATUS, RESP_OKAY);
        chk("sync_on", 32'h2, d & 32'h3);
        give_verdict();
    end
endmodule
